// ==== design/css_pkg.sv ====
/*
 * package for the channel scan sequencer: list entry widths, channel number fields,
 * module capability figures, pairing offset, timing counts and state types.
 * assumes a 40 MHz clock and a scan list loaded by an outside controller.
 */
package css_pkg;
	// ==========================================================
	// channel identifier layout
	localparam int CSS_SLOT_W    = 3;             // slot digit 1..5
	localparam int CSS_CHAN_W    = 7;             // two decimal digits 0..99
	localparam int CSS_ID_W      = CSS_SLOT_W + CSS_CHAN_W;
	localparam int CSS_CFG_W     = 16;            // function/range/rate word
	localparam int CSS_ENT_W     = CSS_ID_W + CSS_CFG_W;
	localparam logic [CSS_SLOT_W-1:0] CSS_SLOT_MIN = 3'h1;
	localparam logic [CSS_SLOT_W-1:0] CSS_SLOT_MAX = 3'h5;
	localparam int CSS_NSLOT     = 5;
	// ==========================================================
	// 22-channel module capability and pairing
	localparam logic [CSS_CHAN_W-1:0] CSS_VCH_FIRST = 7'h01;
	localparam logic [CSS_CHAN_W-1:0] CSS_VCH_LAST  = 7'h14; // 20
	localparam logic [CSS_CHAN_W-1:0] CSS_ACH_FIRST = 7'h15; // 21
	localparam logic [CSS_CHAN_W-1:0] CSS_ACH_LAST  = 7'h16; // 22
	localparam logic [CSS_CHAN_W-1:0] CSS_PAIR_LAST = 7'h0a; // primaries 1..10
	localparam logic [CSS_CHAN_W-1:0] CSS_PAIR_OFS  = 7'h0a; // partner = n + 10
	// ==========================================================
	// relay settle time between open and next close
	localparam int CSS_CLK_MHZ     = 40;
	localparam int CSS_SETTLE_NS   = 100;
	localparam int CSS_SETTLE_CYC  = (CSS_SETTLE_NS * CSS_CLK_MHZ + 999) / 1000;
	localparam int CSS_CNT_W       = 16;
	// ==========================================================
	// measurement modes
	typedef enum logic [1:0] {
		CSS_M_2W,       // single channel
		CSS_M_4W,       // both channels of pair together
		CSS_M_PAIR      // ratio / channel average, one after the other
	} css_mode_t;
	typedef enum {
		CSS_IDLE, CSS_OPEN, CSS_SETTLE, CSS_CLOSE, CSS_WAIT_TRIG,
		CSS_MEAS, CSS_STORE, CSS_OPEN_PRI, CSS_CLOSE_SEC, CSS_MEAS_SEC,
		CSS_NEXT, CSS_PARK
	} css_state_t;
endpackage

// ==== design/css_list_if.sv ====
/*
 * interface carrying scan list memory accesses between the sequencer and
 * its list memory. assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
interface css_list_if #(
	parameter int AW = 6,
	parameter int DW = 26
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== design/css_list_mem.sv ====
/*
 * scan list memory: one entry per listed channel, channel id plus its own
 * measurement setup. read data come out of a register one cycle after raddr.
 * assumes synchronous single clock and a freezing clock enable.
 */
`timescale 1ns/100ps
module css_list_mem #(
	parameter int AW = 6,
	parameter int DW = 26
) (
	input  wire logic clk,
	input  wire logic ce,
	css_list_if.mem   bus
);
	logic [DW-1:0] store [0:(1<<AW)-1];
	logic [DW-1:0] rdata;

	// ==========================================================
	// write port and registered read port; no reset on array contents
	always_ff @(posedge clk) begin
		if (ce) begin
			if (bus.we) begin
				store[bus.waddr] <= bus.wdata;
			end
			rdata <= store[bus.raddr];
		end
	end
	assign bus.rdata = rdata;
endmodule

// ==== design/css_seq.sv ====
/*
 * channel scan sequencer top: walks the scan list, opens and closes relays,
 * requests measurements with each channel's setup, stores readings and pulses
 * the trigger link. assumes the measurement engine answers meas_done and that
 * trigger and delay sources are resolved outside into trig_in.
 */
// What this block does
// - three digit id: slot digit plus two-digit channel
// - each channel measured with its own setup
// - simulated module slots behave like real ones
// - capability: volts 1-20, amps 21-22, slots 1-5
// - sequential scan visits channels in list order; ascending only if loaded so
// - remote list visited exactly in list order
// - every reading stored to buffer automatically; ratio mode stores only the pair result
// - auto clear empties buffer at scan start
// - 2-wire: open, close target, measure, open last
// - 4-wire: open all, close pair, measure
// - primary n pairs with channel n plus 10
// - ratio: primary then partner, result, open partner
// - blank display shows closed unmeasured channel
// - step entry: close first channel, await trigger
// - delays may follow trigger before measuring
// - step: store, pulse trigger, open, close next
// - step end: idle with first channel closed
// - scan: one trigger measures whole list
// - scan: trigger out once per pass at end
// - more passes wait for trigger; end idle
// - output trigger driven onto trigger link
`timescale 1ns/100ps
module css_seq
	import css_pkg::*;
#(
	parameter int AW = 6
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	// list loading
	input  wire logic                  list_we,
	input  wire logic [AW-1:0]         list_waddr,
	input  wire logic [CSS_ID_W-1:0]   list_wid,
	input  wire logic [CSS_CFG_W-1:0]  list_wcfg,
	input  wire logic [AW:0]           list_len,
	// control
	input  wire logic                  start,
	input  wire logic                  step_mode,
	input  wire logic [15:0]           pass_count,
	input  wire logic [1:0]            meas_mode,
	input  wire logic                  auto_clear,
	input  wire logic [CSS_NSLOT-1:0]  slot_present,
	input  wire logic [CSS_NSLOT-1:0]  slot_simulated,
	input  wire logic                  trig_in,
	input  wire logic                  relay_done,
	input  wire logic                  meas_done,
	input  wire logic [CSS_SLOT_W-1:0] cap_slot,
	// outputs
	output logic                       relay_close,
	output logic                       relay_open_all,
	output logic [CSS_ID_W-1:0]        relay_chan,
	output logic                       meas_start,
	output logic [CSS_CFG_W-1:0]       meas_cfg,
	output logic                       buf_store,
	output logic                       buf_clear,
	output logic [CSS_ID_W-1:0]        buf_chan,
	output logic                       calc_pair,
	output logic                       trig_out,
	output logic                       busy,
	output logic                       disp_blank,
	output logic [CSS_ID_W-1:0]        disp_chan,
	output logic [4*CSS_CHAN_W-1:0]    cap_info,
	output logic                       cap_valid
);
	css_list_if #(.AW(AW), .DW(CSS_ENT_W)) lif ();
	css_list_mem #(.AW(AW), .DW(CSS_ENT_W)) u_mem (.clk(clk), .ce(ce), .bus(lif));

	css_state_t            st, next_st;
	logic [AW:0]           idx, next_idx;
	logic [15:0]           pass, next_pass;
	logic [CSS_CNT_W-1:0]  cnt, next_cnt;
	logic                  partner, next_partner;
	logic                  parking, next_parking;
	logic [CSS_ID_W-1:0]   cur_id;
	logic [CSS_CFG_W-1:0]  cur_cfg;
	logic                  slot_ok;
	logic                  last;
	// registered outputs
	logic                  next_close, next_open, next_mstart, next_store, next_clear;
	logic                  next_calc, next_trig, next_blank;
	logic [CSS_ID_W-1:0]   next_rchan, next_dchan;

	// list writes are entered as given; order is the caller's choice
	assign lif.we    = list_we;
	assign lif.waddr = list_waddr;
	assign lif.wdata = {list_wcfg, list_wid};
	assign lif.raddr = idx[AW-1:0];
	assign cur_id    = lif.rdata[CSS_ID_W-1:0];
	assign cur_cfg   = lif.rdata[CSS_ENT_W-1:CSS_ID_W];
	assign last      = (idx + 1'b1 >= list_len);
	// simulated module counts as fitted for setup and run
	assign slot_ok   = (slot_present | slot_simulated) != '0;

	// ==========================================================
	// sequencer next state
	always_comb begin
		next_st      = st;
		next_idx     = idx;
		next_pass    = pass;
		next_cnt     = cnt;
		next_partner = partner;
		next_parking = parking;
		next_close   = 1'b0;
		next_open    = 1'b0;
		next_mstart  = 1'b0;
		next_store   = 1'b0;
		next_clear   = 1'b0;
		next_calc    = 1'b0;
		next_trig    = 1'b0;
		next_blank   = disp_blank;
		next_rchan   = relay_chan;
		next_dchan   = disp_chan;
		case (st)
			CSS_IDLE: begin
				if (start && slot_ok && list_len != '0) begin
					next_clear = auto_clear;
					next_idx   = '0;
					next_pass  = '0;
					next_st    = CSS_OPEN;
				end
			end
			CSS_OPEN: begin
				// every new channel starts from all open
				next_open    = 1'b1;
				next_partner = 1'b0;
				next_st      = CSS_SETTLE;
			end
			CSS_SETTLE: begin
				// wait for relay completion plus a margin before closing
				if (relay_done) begin
					if (cnt >= CSS_CNT_W'(CSS_SETTLE_CYC)) begin
						next_cnt = '0;
						next_st  = partner ? CSS_CLOSE_SEC : (parking ? CSS_PARK : CSS_CLOSE);
					end else begin
						next_cnt = cnt + 1'b1;
					end
				end
			end
			CSS_CLOSE: begin
				next_close = 1'b1;
				if (meas_mode == CSS_M_4W && !partner) begin
					// four-wire: partner first, primary next cycle, both stay closed
					next_rchan   = {cur_id[CSS_ID_W-1:CSS_CHAN_W],
						cur_id[CSS_CHAN_W-1:0] + CSS_PAIR_OFS};
					next_partner = 1'b1;
				end else begin
					next_rchan  = cur_id;
					next_dchan  = cur_id;
					next_blank  = 1'b1;
					next_mstart = !step_mode && idx != '0;
					next_st     = (!step_mode && idx != '0) ? CSS_MEAS : CSS_WAIT_TRIG;
				end
			end
			CSS_WAIT_TRIG: begin
				// outside delays are folded into trig_in
				if (trig_in) begin
					next_mstart = 1'b1;
					next_st     = CSS_MEAS;
				end
			end
			CSS_MEAS: begin
				if (meas_done) begin
					next_store = meas_mode != CSS_M_PAIR;
					next_blank = 1'b0;
					next_st    = (meas_mode == CSS_M_PAIR) ? CSS_OPEN_PRI : CSS_STORE;
				end
			end
			CSS_OPEN_PRI: begin
				// ratio: open primary before its partner is closed
				next_open    = 1'b1;
				next_partner = 1'b1;
				next_st      = CSS_SETTLE;
			end
			CSS_CLOSE_SEC: begin
				next_close  = 1'b1;
				next_rchan  = {cur_id[CSS_ID_W-1:CSS_CHAN_W],
					cur_id[CSS_CHAN_W-1:0] + CSS_PAIR_OFS};
				next_mstart = 1'b1;
				next_st     = CSS_MEAS_SEC;
			end
			CSS_MEAS_SEC: begin
				if (meas_done) begin
					next_calc  = 1'b1;
					next_store = 1'b1;
					next_st    = CSS_STORE;
				end
			end
			CSS_STORE: begin
				if (step_mode) begin
					next_trig = 1'b1;
				end else if (last) begin
					next_trig = 1'b1;
				end
				next_st = CSS_NEXT;
			end
			CSS_NEXT: begin
				if (!last) begin
					next_idx = idx + 1'b1;
					next_st  = CSS_OPEN;
				end else if (!step_mode && pass + 1'b1 < pass_count) begin
					next_pass = pass + 1'b1;
					next_idx  = '0;
					next_st   = CSS_OPEN;
				end else begin
					// park: open the last channel, settle, then close the first again
					next_idx     = '0;
					next_parking = 1'b1;
					next_st      = CSS_OPEN;
				end
			end
			CSS_PARK: begin
				next_close   = 1'b1;
				next_rchan   = cur_id;
				next_parking = 1'b0;
				next_st      = CSS_IDLE;
			end
			default: next_st = CSS_IDLE;
		endcase
	end

	// ==========================================================
	// state and output registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= CSS_IDLE;
			idx <= '0;
			pass <= '0;
			cnt <= '0;
			partner <= 1'b0;
			parking <= 1'b0;
			relay_close <= 1'b0;
			relay_open_all <= 1'b0;
			relay_chan <= '0;
			meas_start <= 1'b0;
			buf_store <= 1'b0;
			buf_clear <= 1'b0;
			calc_pair <= 1'b0;
			trig_out <= 1'b0;
			disp_blank <= 1'b0;
			disp_chan <= '0;
			meas_cfg <= '0;
			buf_chan <= '0;
		end else if (ce) begin
			st <= next_st;
			idx <= next_idx;
			pass <= next_pass;
			cnt <= next_cnt;
			partner <= next_partner;
			parking <= next_parking;
			relay_close <= next_close;
			relay_open_all <= next_open;
			relay_chan <= next_rchan;
			meas_start <= next_mstart;
			buf_store <= next_store;
			buf_clear <= next_clear;
			calc_pair <= next_calc;
			trig_out <= next_trig;
			disp_blank <= next_blank;
			disp_chan <= next_dchan;
			meas_cfg <= cur_cfg;
			buf_chan <= cur_id;
		end
	end
	// ==========================================================
	// capability query for the 22-channel module type
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cap_info <= '0;
			cap_valid <= 1'b0;
			busy <= 1'b0;
		end else if (ce) begin
			cap_info <= {CSS_ACH_LAST, CSS_ACH_FIRST, CSS_VCH_LAST, CSS_VCH_FIRST};
			cap_valid <= (cap_slot >= CSS_SLOT_MIN) && (cap_slot <= CSS_SLOT_MAX);
			busy <= next_st != CSS_IDLE;
		end
	end

	// ==========================================================
	// checks
	property p_trig_once;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_STORE && !step_mode && !last) |=> !trig_out;
	endproperty
	a_trig_once: assert property (p_trig_once) else $error("trigger mid pass");
	property p_step_trig;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_STORE && step_mode) |=> trig_out;
	endproperty
	a_step_trig: assert property (p_step_trig) else $error("no step trigger");
	property p_open_first;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_OPEN) |=> relay_open_all;
	endproperty
	a_open_first: assert property (p_open_first) else $error("no open before close");
	property p_no_overlap;
		@(posedge clk) disable iff (!resetn)
		relay_close |-> !relay_open_all;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("open and close overlap");
	property p_clear;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_IDLE && start && slot_ok && list_len != '0)
			|=> buf_clear == $past(auto_clear);
	endproperty
	a_clear: assert property (p_clear) else $error("auto clear wrong");
	property p_store;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_MEAS_SEC && meas_done) |=> buf_store && calc_pair;
	endproperty
	a_store: assert property (p_store) else $error("pair reading not stored");
	property p_pair;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_CLOSE_SEC) |=>
			relay_chan[CSS_CHAN_W-1:0] == $past(cur_id[CSS_CHAN_W-1:0]) + CSS_PAIR_OFS;
	endproperty
	a_pair: assert property (p_pair) else $error("bad partner");
	property p_blank;
		@(posedge clk) disable iff (!resetn)
		(ce && st == CSS_CLOSE && next_st != CSS_CLOSE) |=> disp_blank && disp_chan == relay_chan;
	endproperty
	a_blank: assert property (p_blank) else $error("blank shows wrong channel");
endmodule

// ==== tb/css_far_model.sv ====
/*
 * far side model: relays of the switching modules, the measurement engine
 * and the trigger source on the trigger link.
 * assumes one-cycle command pulses from the sequencer and one shared clock.
 */
`timescale 1ns/100ps
module css_far_model
	import css_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                relay_close,
	input  wire logic                relay_open_all,
	input  wire logic [CSS_ID_W-1:0] relay_chan,
	input  wire logic                meas_start,
	input  wire logic                trig_en,
	input  wire logic                slow,
	output logic                     relay_done,
	output logic                     meas_done,
	output logic                     trig_in,
	output int                       bad_ids
);
	int relay_cnt;
	int meas_cnt;
	int trig_cnt;
	// ==========================================================
	// relays, meter and trigger, all moved on the falling edge
	always @(negedge clk or negedge resetn) begin
		if (!resetn) begin
			relay_cnt = 0;
			meas_cnt = 0;
			trig_cnt = 0;
			bad_ids = 0;
			relay_done <= 1'b1;
			meas_done <= 1'b0;
			trig_in <= 1'b0;
		end else begin
			// slow relays stretch the wait so settle logic cannot lean on timing
			if (relay_close || relay_open_all) relay_cnt = slow ? 9 : 2;
			else if (relay_cnt > 0) relay_cnt--;
			relay_done <= (relay_cnt == 0);
			// a close outside slots 1..5 or channel 0..99 is a bad id
			if (relay_close && (relay_chan[CSS_ID_W-1:CSS_CHAN_W] < CSS_SLOT_MIN ||
				relay_chan[CSS_ID_W-1:CSS_CHAN_W] > CSS_SLOT_MAX ||
				relay_chan[CSS_CHAN_W-1:0] > 7'h63)) bad_ids++;
			meas_done <= (meas_cnt == 1);
			if (meas_start) meas_cnt = slow ? 12 : 3;
			else if (meas_cnt > 0) meas_cnt--;
			// trigger events come free running; ones outside waits are lost
			trig_cnt = (trig_cnt + 1) % 24;
			trig_in <= trig_en && (trig_cnt == 0);
		end
	end
endmodule

// ==== tb/css_seq_tb_top.sv ====
/*
 * self-checking bench for the channel scan sequencer with a far side model.
 * assumes a 40 MHz clock and that the design and package compile first.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module css_seq_tb_top
	import css_pkg::*;
();
	logic                  clk            = 1'b0;
	logic                  resetn         = 1'b0;
	logic                  ce             = 1'b1;
	logic                  list_we        = 1'b0;
	logic [5:0]            list_waddr     = 6'h00;
	logic [CSS_ID_W-1:0]   list_wid       = '0;
	logic [CSS_CFG_W-1:0]  list_wcfg      = '0;
	logic [6:0]            list_len       = 7'h00;
	logic                  start          = 1'b0;
	logic                  step_mode      = 1'b0;
	logic [15:0]           pass_count     = 16'h0001;
	logic [1:0]            meas_mode      = 2'h0;
	logic                  auto_clear     = 1'b1;
	logic [CSS_NSLOT-1:0]  slot_present   = 5'h00;
	logic [CSS_NSLOT-1:0]  slot_simulated = 5'h00;
	logic [CSS_SLOT_W-1:0] cap_slot       = 3'h0;
	logic                  trig_en        = 1'b0;
	logic                  slow           = 1'b0;
	logic                  trig_in, relay_done, meas_done, relay_close, relay_open_all;
	logic                  meas_start, buf_store, buf_clear, calc_pair, trig_out;
	logic                  busy, disp_blank, cap_valid;
	logic [CSS_ID_W-1:0]   relay_chan, buf_chan, disp_chan;
	logic [CSS_CFG_W-1:0]  meas_cfg;
	logic [4*CSS_CHAN_W-1:0] cap_info;
	int                    num_errors, comparisons, bad_ids, n_trig, n_clr, n_pair;
	int                    seed = 66;
	logic [CSS_ID_W-1:0]   ids [8];
	logic [CSS_CFG_W-1:0]  cfgs [8];
	logic [CSS_ID_W-1:0]   q_store [$];
	logic [CSS_ID_W-1:0]   q_close [$];
	logic [CSS_CFG_W-1:0]  q_cfg [$];

	always #12.5 clk = ~clk;

	css_seq #(.AW(6)) u_dut (.clk(clk), .resetn(resetn), .ce(ce), .list_we(list_we),
		.list_waddr(list_waddr), .list_wid(list_wid), .list_wcfg(list_wcfg),
		.list_len(list_len), .start(start), .step_mode(step_mode), .pass_count(pass_count),
		.meas_mode(meas_mode), .auto_clear(auto_clear), .slot_present(slot_present),
		.slot_simulated(slot_simulated), .trig_in(trig_in), .relay_done(relay_done),
		.meas_done(meas_done), .cap_slot(cap_slot), .relay_close(relay_close),
		.relay_open_all(relay_open_all), .relay_chan(relay_chan), .meas_start(meas_start),
		.meas_cfg(meas_cfg), .buf_store(buf_store), .buf_clear(buf_clear),
		.buf_chan(buf_chan), .calc_pair(calc_pair), .trig_out(trig_out), .busy(busy),
		.disp_blank(disp_blank), .disp_chan(disp_chan), .cap_info(cap_info),
		.cap_valid(cap_valid));

	css_far_model u_far (.clk(clk), .resetn(resetn), .relay_close(relay_close),
		.relay_open_all(relay_open_all), .relay_chan(relay_chan), .meas_start(meas_start),
		.trig_en(trig_en), .slow(slow), .relay_done(relay_done), .meas_done(meas_done),
		.trig_in(trig_in), .bad_ids(bad_ids));

	// ==========================================================
	// monitor: log pulses in the cycle they stand
	always @(negedge clk) begin
		if (buf_store) q_store.push_back(buf_chan);
		if (meas_start) q_cfg.push_back(meas_cfg);
		if (relay_close) q_close.push_back(relay_chan);
		n_trig += trig_out;
		n_clr += buf_clear;
		n_pair += calc_pair;
	end

	// partner of primary n is n plus 10 in the channel digits
	function automatic logic [CSS_ID_W-1:0] pair_of(input logic [CSS_ID_W-1:0] id);
		return id + 10'h00a;
	endfunction

	// volts first, volts last, amps first, amps last
	function automatic logic [4*CSS_CHAN_W-1:0] cap_exp();
		return {7'h16, 7'h15, 7'h14, 7'h01};
	endfunction

	// ascending lists stay in slot 1 so that order is plain channel order
	task automatic load(input int n, input bit ascend);
		for (int i = 0; i < n; i++) begin
			if (ascend) ids[i] = {3'h1, 7'(2 * i + 1 + ($unsigned($random(seed)) % 2))};
			else ids[i] = {3'(1 + $unsigned($random(seed)) % 5),
				7'(1 + $unsigned($random(seed)) % 10)};
			cfgs[i] = 16'($random(seed));
			@(negedge clk);
			list_we = 1'b1;
			list_waddr = 6'(i);
			list_wid = ids[i];
			list_wcfg = cfgs[i];
		end
		@(negedge clk);
		list_we = 1'b0;
		list_len = 7'(n);
	endtask

	// a refused start never raises busy, so the first wait runs out quietly
	task automatic run(input bit step, input logic [1:0] mode, input int passes,
		input bit clr);
		int k;
		q_store.delete();
		q_close.delete();
		q_cfg.delete();
		n_trig = 0;
		n_clr = 0;
		n_pair = 0;
		@(negedge clk);
		step_mode = step;
		meas_mode = mode;
		pass_count = 16'(passes);
		auto_clear = clr;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		k = 0;
		while (busy !== 1'b1 && k < 20) begin @(negedge clk); k++; end
		while (busy !== 1'b0 && k < 20000) begin @(negedge clk); k++; end
		if (k >= 20000) `CHK(busy, 1'b0)
		repeat (4) @(negedge clk);
	endtask

	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		#1500000;
		num_errors++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		trig_en = 1'b1;
		for (int s = 0; s < 8; s++) begin
			cap_slot = 3'(s);
			repeat (3) @(negedge clk);
			`CHK(cap_valid, (s >= 1 && s <= 5))
			if (s >= 1 && s <= 5) `CHK(cap_info, cap_exp())
		end
		// scan of a random list, two passes, simulated slots, slow relays
		slot_simulated = 5'h1f;
		slow = 1'b1;
		load(5, 0);
		run(0, 2'h0, 2, 1);
		`CHK(q_store.size(), 10)
		for (int i = 0; i < 10; i++) `CHK(q_store[i], ids[i % 5])
		for (int i = 0; i < 10; i++) `CHK(q_cfg[i], cfgs[i % 5])
		`CHK(n_trig, 2)
		`CHK(n_clr, 1)
		`CHK(relay_chan, ids[0])
		// single step, ascending list, appended readings, real slot
		slot_simulated = 5'h00;
		slot_present = 5'h01;
		slow = 1'b0;
		load(4, 1);
		run(1, 2'h0, 1, 0);
		`CHK(q_store.size(), 4)
		for (int i = 0; i < 3; i++) `CHK(q_store[i] < q_store[i + 1], 1'b1)
		`CHK(n_trig, 4)
		`CHK(n_clr, 0)
		`CHK(relay_chan, ids[0])
		// ratio pairs then four-wire pairs
		load(3, 0);
		run(0, 2'h2, 1, 1);
		`CHK(q_store.size(), 3)
		`CHK(n_pair, 3)
		`CHK(q_close[0], ids[0])
		`CHK(q_close[1], pair_of(ids[0]))
		`CHK(n_trig, 1)
		run(0, 2'h1, 1, 1);
		`CHK(q_store.size(), 3)
		`CHK(q_close[0], pair_of(ids[0]))
		`CHK(q_close[1], ids[0])
		// refused starts: empty list, then no module at all
		list_len = 7'h00;
		run(0, 2'h0, 1, 1);
		`CHK(q_store.size(), 0)
		list_len = 7'h03;
		slot_present = 5'h00;
		run(0, 2'h0, 1, 1);
		`CHK(n_clr, 0)
		`CHK(bad_ids, 0)
		conclude();
	end
endmodule
